// file: hdl/idt_pkg.sv
/*
 * Shared definitions for the instruction decode and timing block: opcode
 * map, operand classes, cycle figures, register offsets and decoded-word layout.
 * Assumes a single instruction clock shared by fetch, decode and datapath.
 */
package idt_pkg;
   // ==========================================================
   // Word geometry and opcode map
   localparam int IDT_WORD_W = 24;
   localparam logic [7:0] OPC_NOP = 8'h00;
   localparam logic [7:0] OPC_JREL = 8'h01;
   localparam logic [7:0] OPC_CALL = 8'h02;
   localparam logic [7:0] OPC_IND = 8'h03;
   localparam logic [7:0] OPC_GOTO = 8'h04;
   localparam logic [7:0] OPC_RET = 8'h05;
   localparam logic [7:0] OPC_IEXIT = 8'h06;
   localparam logic [7:0] OPC_DO = 8'h07;
   localparam logic [5:0] OPC_TBL = 6'h02;
   localparam logic [5:0] OPC_SKIP = 6'h03;
   localparam logic [5:0] OPC_MOVD = 6'h04;
   localparam logic [2:0] GRP_WOP = 3'h1;
   localparam logic [2:0] GRP_FOP = 3'h2;
   localparam logic [2:0] GRP_BIT = 3'h3;
   localparam logic [2:0] GRP_LIT = 3'h4;
   localparam logic [2:0] GRP_MAC = 3'h5;
   localparam logic [2:0] GRP_DSP = 3'h6;
   localparam logic [7:0] EXT_HI_ZERO = 8'h00;
   localparam logic [9:0] IMM10_BYTE_MAX = 10'h0ff;
   localparam logic [1:0] WID_WORD = 2'h0;
   localparam logic [1:0] WID_BYTE = 2'h1;
   localparam logic [1:0] WID_DWORD = 2'h2;
   localparam logic [1:0] AWB_NONE = 2'h0;
   localparam logic [1:0] AWB_DIRECT = 2'h1;
   localparam logic [1:0] AWB_POSTINC = 2'h2;
   localparam logic [3:0] AWB_REG = 4'hd;
   localparam logic [1:0] DSP_REG_BASE = 2'h1;
   // ==========================================================
   // Instruction cycle figures
   localparam logic [1:0] CYC_SINGLE = 2'h1;
   localparam logic [1:0] CYC_TWO_WORD = 2'h2;
   localparam logic [1:0] CYC_LONG2 = 2'h2;
   localparam logic [1:0] CYC_LONG3 = 2'h3;
   localparam logic [1:0] CYC_MOVD = 2'h2;
   localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
   localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
   // ==========================================================
   // Register map (byte addresses) and reset values
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_WORD1 = 5'h08;
   localparam logic [4:0] REG_WORD2 = 5'h0c;
   localparam logic [4:0] REG_FLAGS = 5'h10;
   localparam logic [4:0] REG_CYCLES = 5'h14;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam int STATUS_ILL_BIT = 3;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_FETCH1 = 3'b000, ST_FETCH2 = 3'b001, ST_EXEC = 3'b010,
      ST_STALL = 3'b011, ST_SKIP1 = 3'b100, ST_SKIP2 = 3'b101
   } idt_state_t;
   typedef enum logic [3:0] {
      CL_NOP = 4'h0, CL_TWO = 4'h1, CL_JREL = 4'h2, CL_IND = 4'h3,
      CL_RET = 4'h4, CL_TBL = 4'h5, CL_SKIP = 4'h6, CL_MOVD = 4'h7,
      CL_WOP = 4'h8, CL_FOP = 4'h9, CL_BIT = 4'ha, CL_LIT = 4'hb,
      CL_MAC = 4'hc, CL_DSP = 4'hd, CL_ILL = 4'he
   } idt_class_t;
   typedef struct packed {
      logic carry_flag; logic digit_carry_flag; logic neg_flag;
      logic signed_wrap_flag; logic zero_flag;
      logic acc_a_wrap_flag; logic acc_b_wrap_flag;
      logic acc_a_clamp_flag; logic acc_b_clamp_flag;
   } idt_flags_t;
   typedef struct packed {
      logic [7:0] opcode; idt_class_t iclass; logic [1:0] width; logic shadow;
      logic two_word; logic illegal; logic acc_b;
      logic [3:0] base_work_reg; logic [3:0] source_operand; logic [1:0] src_mode;
      logic [3:0] dest_operand; logic [1:0] dst_mode;
      logic [12:0] file_addr; logic to_wreg0;
      logic [3:0] bit_select_field; logic bit_indirect;
      logic [9:0] imm10_field; logic [22:0] imm23_field;
      logic [3:0] mul_m; logic [3:0] mul_n;
      logic [3:0] xpf_op; logic [3:0] x_dest; logic [3:0] ypf_op; logic [3:0] y_dest;
      logic [1:0] awb_mode; logic [3:0] acc_writeback_reg;
      logic [5:0] shift_lit; logic shift_by_reg; logic [3:0] shift_reg;
      logic [1:0] tbl_mode;
   } idt_dec_t;
endpackage : idt_pkg

// file: hdl/idt_decoder.sv
/*
 * Instruction word decoder and cycle sequencer with its Avalon-MM register
 * slave. Assumes program memory on the same clock answering o_fetch_req with
 * i_pm_valid, and a datapath that drives i_cond_true while o_dec_valid is high.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
module idt_decoder (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_fetch_req,
   input wire logic i_pm_valid,
   input wire logic [23:0] i_pm_word,
   input wire logic i_cond_true,
   input wire idt_pkg::idt_flags_t i_flag_upd,
   input wire idt_pkg::idt_flags_t i_flag_val,
   output idt_pkg::idt_dec_t o_dec,
   output logic o_dec_valid,
   output logic o_nop_cycle,
   output idt_pkg::idt_flags_t o_flags
);
   import idt_pkg::*;

   // ==========================================================
   // Opcode classification
   function automatic idt_class_t classify(input logic [7:0] op);
      idt_class_t c;
      c = CL_ILL;
      if (op == OPC_NOP) c = CL_NOP;
      else if (op == OPC_CALL || op == OPC_GOTO || op == OPC_DO) c = CL_TWO;
      else if (op == OPC_JREL) c = CL_JREL;
      else if (op == OPC_IND) c = CL_IND;
      else if (op == OPC_RET || op == OPC_IEXIT) c = CL_RET;
      else if (op[7:2] == OPC_TBL) c = CL_TBL;
      else if (op[7:2] == OPC_SKIP) c = CL_SKIP;
      else if (op[7:2] == OPC_MOVD) c = CL_MOVD;
      else if (op[7:5] == GRP_WOP) c = CL_WOP;
      else if (op[7:5] == GRP_FOP) c = CL_FOP;
      else if (op[7:5] == GRP_BIT) c = CL_BIT;
      else if (op[7:5] == GRP_LIT) c = CL_LIT;
      else if (op[7:5] == GRP_MAC) c = CL_MAC;
      else if (op[7:5] == GRP_DSP) c = CL_DSP;
      return c;
   endfunction : classify

   // ==========================================================
   // Operand field split; w2 only matters for two-word classes
   function automatic idt_dec_t decode(input logic [23:0] w1, input logic [23:0] w2);
      idt_dec_t d;
      logic [7:0] op;
      logic [15:0] f;
      d = '0;
      op = w1[23:16];
      f = w1[15:0];
      d.opcode = op;
      d.iclass = classify(op);
      d.width = WID_WORD;
      d.acc_writeback_reg = AWB_REG;
      case (d.iclass)
         CL_TWO: begin
            d.two_word = 1'b1;
            d.imm23_field = {w2[6:0], f[15:1], 1'b0};
            d.illegal = (w2[23:16] != EXT_HI_ZERO) | f[0];
         end
         CL_TBL: begin
            d.tbl_mode = op[1:0];
            d.width = op[0] ? WID_BYTE : WID_WORD;
            d.source_operand = f[3:0];
            d.src_mode = f[5:4];
            d.dest_operand = f[9:6];
            d.dst_mode = f[11:10];
         end
         CL_JREL, CL_IND: d.source_operand = f[3:0];
         CL_MOVD: begin
            d.width = WID_DWORD;
            d.source_operand = f[3:0];
            d.dest_operand = f[7:4];
         end
         CL_WOP: begin
            d.width = op[0] ? WID_BYTE : WID_WORD;
            d.shadow = op[1];
            d.base_work_reg = f[15:12];
            d.source_operand = f[11:8];
            d.src_mode = f[7:6];
            d.dest_operand = f[5:2];
            d.dst_mode = f[1:0];
         end
         CL_FOP: begin
            d.to_wreg0 = op[0];
            d.width = op[1] ? WID_BYTE : WID_WORD;
            d.file_addr = f[12:0];
         end
         CL_BIT: begin
            d.bit_select_field = f[15:12];
            d.bit_indirect = op[1];
            d.base_work_reg = f[11:8];
            if (op[0]) begin
               d.file_addr = {5'h00, f[7:0]};
            end else begin
               d.source_operand = f[3:0];
               d.src_mode = f[5:4];
            end
         end
         CL_LIT: begin
            d.width = op[0] ? WID_BYTE : WID_WORD;
            if (op[1]) begin
               d.base_work_reg = f[15:12];
               d.dest_operand = f[11:8];
               d.dst_mode = f[7:6];
               d.imm10_field = {5'h00, f[4:0]};
            end else begin
               d.base_work_reg = f[3:0];
               d.dest_operand = f[3:0];
               d.imm10_field = f[13:4];
            end
            d.illegal = op[0] && (d.imm10_field > IMM10_BYTE_MAX);
         end
         CL_MAC: begin
            d.acc_b = op[0];
            if (op[1]) begin
               d.mul_m = {DSP_REG_BASE, f[14:13]};
               d.mul_n = {DSP_REG_BASE, f[14:13]};
               d.illegal = f[15];
            end else begin
               case (f[15:13])
                  3'h0: {d.mul_m, d.mul_n} = {4'h4, 4'h5};
                  3'h1: {d.mul_m, d.mul_n} = {4'h4, 4'h6};
                  3'h2: {d.mul_m, d.mul_n} = {4'h4, 4'h7};
                  3'h3: {d.mul_m, d.mul_n} = {4'h5, 4'h6};
                  3'h4: {d.mul_m, d.mul_n} = {4'h5, 4'h7};
                  3'h5: {d.mul_m, d.mul_n} = {4'h6, 4'h7};
                  default: d.illegal = 1'b1;
               endcase
            end
            d.xpf_op = f[12:9];
            d.x_dest = {DSP_REG_BASE, f[8:7]};
            d.ypf_op = f[6:3];
            d.y_dest = {DSP_REG_BASE, f[2:1]};
            d.awb_mode = !op[2] ? AWB_NONE : (f[0] ? AWB_POSTINC : AWB_DIRECT);
         end
         CL_DSP: begin
            d.acc_b = op[0];
            d.shift_by_reg = op[1];
            d.source_operand = f[3:0];
            d.src_mode = f[5:4];
            d.base_work_reg = f[9:6];
            d.shift_lit = f[15:10];
            d.shift_reg = f[13:10];
         end
         CL_ILL: d.illegal = 1'b1;
         default: d.illegal = 1'b0;
      endcase
      return d;
   endfunction : decode

   // ==========================================================
   // State and datapath registers
   idt_state_t st_q, st_d;
   logic [1:0] cnt_q, cnt_d;
   logic [1:0] cyc_q, cyc_d;
   logic [23:0] word1_q, word2_q;
   logic run_q, ill_q, accept, ext_two;
   logic bus_req, bus_wr, bus_rd;
   idt_flags_t flags_nx;

   assign accept = o_fetch_req & i_pm_valid;
   assign ext_two = (classify(i_pm_word[23:16]) == CL_TWO);
   assign bus_req = i_avs_read | i_avs_write;
   assign bus_wr = i_avs_write & ~o_avs_waitrequest;
   assign bus_rd = i_avs_read & o_avs_waitrequest;

   // Sequencer: each class is held for its documented cycle count
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cyc_d = cyc_q;
      case (st_q)
         ST_FETCH1: if (accept) st_d = ext_two ? ST_FETCH2 : ST_EXEC;
         ST_FETCH2: if (accept) st_d = ST_EXEC;
         ST_EXEC: begin
            case (o_dec.iclass)
               CL_TWO: cyc_d = CYC_TWO_WORD;
               CL_JREL, CL_IND: cyc_d = CYC_LONG2;
               CL_RET, CL_TBL: cyc_d = CYC_LONG3;
               CL_MOVD: cyc_d = CYC_MOVD;
               default: cyc_d = i_cond_true ? CYC_SINGLE + 2'h1 : CYC_SINGLE;
            endcase
            cnt_d = cyc_d - 2'h1;
            if (o_dec.iclass == CL_SKIP && i_cond_true) st_d = ST_SKIP1;
            else st_d = (cnt_d == 2'h0) ? ST_FETCH1 : ST_STALL;
         end
         ST_SKIP1: begin
            // Skipped word is fetched only to learn its length
            if (accept) begin
               cyc_d = ext_two ? CYC_SKIP_TWO : CYC_SKIP_ONE;
               cnt_d = cyc_d - 2'h1;
               st_d = ext_two ? ST_SKIP2 : ST_STALL;
            end
         end
         ST_SKIP2: if (accept) st_d = ST_STALL;
         ST_STALL: begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) st_d = ST_FETCH1;
         end
         default: st_d = ST_FETCH1;
      endcase
   end

   // State, counters and fetch request
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= ST_FETCH1;
         cnt_q <= 2'h0;
         cyc_q <= 2'h0;
         o_fetch_req <= 1'b0;
         o_nop_cycle <= 1'b0;
         o_dec_valid <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         cyc_q <= cyc_d;
         o_fetch_req <= (st_d == ST_FETCH1 && run_q) || st_d == ST_FETCH2 ||
                        st_d == ST_SKIP1 || st_d == ST_SKIP2;
         o_nop_cycle <= (st_d == ST_STALL);
         o_dec_valid <= (st_d == ST_EXEC);
      end
   end

   // Word capture; a second word never reaches decode on its own
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         word1_q <= 24'h000000;
         word2_q <= 24'h000000;
         o_dec <= '0;
      end else begin
         if (st_q == ST_FETCH1 && accept) word1_q <= i_pm_word;
         if (st_q == ST_FETCH2 && accept) word2_q <= i_pm_word;
         if (st_q == ST_FETCH1 && accept && !ext_two) o_dec <= decode(i_pm_word, 24'h000000);
         else if (st_q == ST_FETCH2 && accept) o_dec <= decode(word1_q, i_pm_word);
      end
   end

   // Status flags: hardware updates applied after a software write
   always_comb begin
      flags_nx = o_flags;
      if (bus_wr && i_avs_address == REG_FLAGS) begin
         if (i_avs_byteenable[0]) flags_nx[7:0] = i_avs_writedata[7:0];
         if (i_avs_byteenable[1]) flags_nx[8] = i_avs_writedata[8];
      end
      if (i_flag_upd.carry_flag) flags_nx.carry_flag = i_flag_val.carry_flag;
      if (i_flag_upd.digit_carry_flag) flags_nx.digit_carry_flag = i_flag_val.digit_carry_flag;
      if (i_flag_upd.neg_flag) flags_nx.neg_flag = i_flag_val.neg_flag;
      if (i_flag_upd.signed_wrap_flag) flags_nx.signed_wrap_flag = i_flag_val.signed_wrap_flag;
      // Sticky zero: an update can only clear it
      if (i_flag_upd.zero_flag) flags_nx.zero_flag = flags_nx.zero_flag & i_flag_val.zero_flag;
      if (i_flag_upd.acc_a_wrap_flag) flags_nx.acc_a_wrap_flag = i_flag_val.acc_a_wrap_flag;
      if (i_flag_upd.acc_b_wrap_flag) flags_nx.acc_b_wrap_flag = i_flag_val.acc_b_wrap_flag;
      // Clamp flags are sticky, so a set beats a same-cycle software clear
      if (i_flag_upd.acc_a_clamp_flag) flags_nx.acc_a_clamp_flag = flags_nx.acc_a_clamp_flag |
                                                                   i_flag_val.acc_a_clamp_flag;
      if (i_flag_upd.acc_b_clamp_flag) flags_nx.acc_b_clamp_flag = flags_nx.acc_b_clamp_flag |
                                                                   i_flag_val.acc_b_clamp_flag;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) o_flags <= '0;
      else o_flags <= flags_nx;
   end

   // ==========================================================
   // Avalon-MM slave: one wait state on every access
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else begin
         o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
         if (bus_rd) begin
            if (i_avs_address == REG_CTRL) o_avs_readdata <= {31'h0, run_q};
            else if (i_avs_address == REG_STATUS) o_avs_readdata <= {28'h0, ill_q, st_q};
            else if (i_avs_address == REG_WORD1) o_avs_readdata <= {8'h00, word1_q};
            else if (i_avs_address == REG_WORD2) o_avs_readdata <= {8'h00, word2_q};
            else if (i_avs_address == REG_FLAGS) o_avs_readdata <= {23'h0, o_flags};
            else if (i_avs_address == REG_CYCLES) o_avs_readdata <= {30'h0, cyc_q};
            else o_avs_readdata <= 32'h00000000;
         end
      end
   end

   // Run enable and sticky illegal-word flag (write one to clear, set wins)
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_q <= CTRL_RUN_RST;
         ill_q <= 1'b0;
      end else begin
         if (bus_wr && i_avs_address == REG_CTRL && i_avs_byteenable[0])
            run_q <= i_avs_writedata[0];
         if (o_dec_valid && o_dec.illegal) ill_q <= 1'b1;
         else if (bus_wr && i_avs_address == REG_STATUS && i_avs_byteenable[0] &&
                  i_avs_writedata[STATUS_ILL_BIT]) ill_q <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   property p_two_word_fetch;
      st_q == ST_FETCH1 && accept && ext_two |=> st_q == ST_FETCH2 ##0 o_fetch_req;
   endproperty
   a_two_word_fetch: assert property (p_two_word_fetch) else $error("no second fetch");

   property p_two_word_cycles;
      o_dec_valid && o_dec.iclass == CL_TWO |=> o_nop_cycle ##1 !o_nop_cycle;
   endproperty
   a_two_word_cycles: assert property (p_two_word_cycles) else $error("two-word timing");

   property p_lone_ext_nop;
      o_dec_valid && o_dec.opcode == OPC_NOP && !i_cond_true |=> !o_nop_cycle && !o_dec_valid;
   endproperty
   a_lone_ext_nop: assert property (p_lone_ext_nop) else $error("second word not nop");

   property p_single_taken;
      o_dec_valid && o_dec.iclass == CL_WOP && i_cond_true |=> o_nop_cycle ##1 !o_nop_cycle;
   endproperty
   a_single_taken: assert property (p_single_taken) else $error("taken single timing");

   property p_long3;
      o_dec_valid && o_dec.iclass == CL_RET |=> o_nop_cycle [*2] ##1 !o_nop_cycle;
   endproperty
   a_long3: assert property (p_long3) else $error("return timing");

   property p_skip_two;
      st_q == ST_SKIP1 && accept && ext_two |=> st_q == ST_SKIP2 && cyc_q == CYC_SKIP_TWO;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip over two words");

   property p_movd;
      o_dec_valid && o_dec.iclass == CL_MOVD |-> o_dec.width == WID_DWORD ##1 o_nop_cycle;
   endproperty
   a_movd: assert property (p_movd) else $error("double move timing");

   property p_imm10;
      o_dec_valid && o_dec.iclass == CL_LIT && o_dec.width == WID_BYTE &&
      o_dec.imm10_field > IMM10_BYTE_MAX |-> o_dec.illegal ##1 ill_q;
   endproperty
   a_imm10: assert property (p_imm10) else $error("byte literal range");

   property p_imm23;
      o_dec_valid && o_dec.two_word |-> o_dec.imm23_field[0] == 1'b0 && (!word1_q[0] || o_dec.illegal);
   endproperty
   a_imm23: assert property (p_imm23) else $error("address lsb set");

   property p_pairs;
      o_dec_valid && o_dec.iclass == CL_MAC && !o_dec.illegal |->
      o_dec.mul_m >= 4'h4 && o_dec.mul_n <= 4'h7 &&
      (o_dec.opcode[1] ? o_dec.mul_m == o_dec.mul_n : o_dec.mul_m < o_dec.mul_n);
   endproperty
   a_pairs: assert property (p_pairs) else $error("bad multiply pair");

   property p_sticky_zero;
      i_flag_upd.zero_flag && !i_flag_val.zero_flag && !bus_wr |=> !o_flags.zero_flag;
   endproperty
   a_sticky_zero: assert property (p_sticky_zero) else $error("zero flag not cleared");

   property p_bus_answer;
      bus_req && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule : idt_decoder

// file: testbench/idt_pm_model.sv
/*
 * Program memory model feeding 24-bit words to the decoder fetch port.
 * Assumes the bench fills mem before reset is released.
 */
module idt_pm_model (
   input wire logic i_clk_sys,
   input wire logic i_fetch_req,
   input wire logic i_slow,
   output logic o_pm_valid,
   output logic [23:0] o_pm_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Storage and fetch pointer
   logic [23:0] mem [0:63];
   logic [5:0] addr_q = 6'h00;
   logic [23:0] last_q = 24'h000000;
   // Stalls leave an inverted stale word so a missed valid check shows up
   assign o_pm_valid = i_fetch_req & ~i_slow;
   assign o_pm_word = o_pm_valid ? mem[addr_q] : ~last_q;
   // Advance only on an accepted word
   always @(posedge i_clk_sys) begin
      if (o_pm_valid) begin
         addr_q <= addr_q + 6'h01;
         last_q <= mem[addr_q];
      end
   end
endmodule : idt_pm_model

// file: testbench/tb_top.sv
/*
 * Self-checking bench for the decoder: program timing, flags, register bus.
 * Assumes the decoder and the program memory model share one clock.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import idt_pkg::*;
   typedef struct packed {logic [7:0] opc; logic cnd; logic [1:0] cyc; logic two;} idt_exp_t;
   // ==========================================================
   // Signals
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] o_avs_readdata, rd;
   logic o_avs_waitrequest, o_fetch_req, pm_valid, i_cond_true = 1'b0, slow = 1'b0;
   logic [23:0] pm_word;
   idt_flags_t upd = '0, val = '0, o_flags;
   idt_dec_t o_dec;
   logic o_dec_valid, o_nop_cycle, have = 1'b0;
   logic [8:0] fv;
   int seed = 71, n_mismatch = 0, n_tests = 0, n = 0, n_nop = 0, k;
   idt_exp_t exp_q[$], cur;
   always #50 i_clk_sys = ~i_clk_sys;
   idt_decoder u_idt_decoder (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_fetch_req(o_fetch_req),
      .i_pm_valid(pm_valid), .i_pm_word(pm_word), .i_cond_true(i_cond_true),
      .i_flag_upd(upd), .i_flag_val(val), .o_dec(o_dec), .o_dec_valid(o_dec_valid),
      .o_nop_cycle(o_nop_cycle), .o_flags(o_flags));
   idt_pm_model u_idt_pm_model (.i_clk_sys(i_clk_sys), .i_fetch_req(o_fetch_req),
      .i_slow(slow), .o_pm_valid(pm_valid), .o_pm_word(pm_word));
   // ==========================================================
   // Tasks
   task conclude;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Hold the request until waitrequest is sampled low; the wait has no bound of its own
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      rd_s <= ~w;
      wr_s <= w;
      adr <= a;
      wd <= d;
      // No cycle count assumed; the watchdog ends a hung wait
      do begin
         @(posedge i_clk_sys);
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask : bus
   task put(input logic [23:0] w, input logic c, input logic [1:0] y, input logic t);
      u_idt_pm_model.mem[n++] = w;
      exp_q.push_back({w[23:16], c, y, t});
   endtask : put
   task raw(input logic [23:0] w);
      u_idt_pm_model.mem[n++] = w;
   endtask : raw
   // ==========================================================
   // Monitor: cycle count of each instruction and its decode
   always @(posedge i_clk_sys) begin
      slow <= ($random(seed) % 4) == 0;
      if (o_nop_cycle === 1'b1) n_nop++;
      if (o_dec_valid === 1'b1) begin
         if (have) chk(n_nop + 1, cur.cyc);
         n_nop = 0;
         have = exp_q.size() > 0;
         if (have) begin
            cur = exp_q.pop_front();
            chk(o_dec.opcode, cur.opc);
            chk(o_dec.two_word, cur.two);
            i_cond_true <= exp_q.size() > 0 ? exp_q[0].cnd : 1'b0;
         end
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 64; i++) u_idt_pm_model.mem[i] = 24'h000000;
      put(24'h000000, 0, 1, 0);
      put(24'h010010, 0, 2, 0);
      put(24'h030005, 0, 2, 0);
      put(24'h050000, 0, 3, 0);
      put(24'h060000, 0, 3, 0);
      put(24'h0a0001, 0, 3, 0);
      put(24'h020100, 0, 2, 1); raw(24'h000001);
      put(24'h040200, 0, 2, 1); raw(24'h000002);
      put(24'h070000, 0, 2, 1); raw(24'h000003);
      put(24'h100000, 0, 2, 0);
      put(24'h0c0000, 1, 2, 0); raw(24'h210000);
      put(24'h0d0000, 1, 3, 0); raw(24'h040000); raw(24'h000000);
      put(24'h0e0000, 0, 1, 0);
      put(24'h00abcd, 0, 1, 0);
      put(24'h813ff0, 0, 1, 0);
      put(24'ha00000, 0, 1, 0);
      put(24'ha20000, 0, 1, 0);
      for (int i = 0; i < 8; i++) begin
         k = $random(seed);
         put({3'b001, k[20:0]}, k[21], k[21] ? 2'h2 : 2'h1, 0);
      end
      put(24'h000000, 0, 1, 0);
      i_cond_true = exp_q[0].cnd;
      repeat (6) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      bus(0, REG_CTRL, 0); chk(rd, {31'h0, CTRL_RUN_RST});
      bus(1, 5'h18, 32'hffffffff);
      bus(0, 5'h18, 0); chk(rd, 32'h0);
      fv = 9'($random(seed));
      @(posedge i_clk_sys);
      upd <= '1;
      val <= fv;
      @(posedge i_clk_sys);
      upd <= '0;
      @(posedge i_clk_sys);
      chk(o_flags, fv & 9'h1ef);
      bus(0, REG_FLAGS, 0); chk(rd[8:0], fv & 9'h1ef);
      // A stalled program is caught by the watchdog, never passed
      while (exp_q.size() > 0) begin
         @(posedge i_clk_sys);
      end
      repeat (8) @(posedge i_clk_sys);
      bus(0, REG_CYCLES, 0); chk(rd[1:0], CYC_SINGLE);
      bus(0, REG_STATUS, 0); chk(rd[3], 1'b1);
      bus(1, REG_STATUS, 32'h00000008);
      bus(0, REG_STATUS, 0); chk(rd[3], 1'b0);
      conclude;
   end
   // Watchdog sized well past the expected run length
   initial begin
      #(5000 * 100);
      n_mismatch++;
      conclude;
   end
endmodule : tb_top
